// File: bridge_pkg.sv
// Shared constants, carrier types and command decode for the bridge filter.
package bridge_pkg;

   // Bus command codes seen on the command/byte-enable lines.
   localparam logic [3:0] CMD_INTACK  = 4'h0;
   localparam logic [3:0] CMD_SPECIAL = 4'h1;
   localparam logic [3:0] CMD_IO_RD   = 4'h2;
   localparam logic [3:0] CMD_IO_WR   = 4'h3;
   localparam logic [3:0] CMD_MEM_RD  = 4'h6;
   localparam logic [3:0] CMD_MEM_WR  = 4'h7;
   localparam logic [3:0] CMD_CFG_RD  = 4'ha;
   localparam logic [3:0] CMD_CFG_WR  = 4'hb;
   localparam logic [3:0] CMD_MEM_RDM = 4'hc;
   localparam logic [3:0] CMD_MEM_WRM = 4'hd;
   localparam logic [3:0] CMD_MEM_RDL = 4'he;
   localparam logic [3:0] CMD_MEM_WRL = 4'hf;

   // Counts and reset values.
   localparam int         NUM_MASTERS  = 9;
   localparam int         FIFO_DEPTH   = 8;
   localparam int         MAX_BUS_MHZ  = 66;
   localparam int         CLK_MHZ      = 50;
   localparam logic [8:0] GNT_IDLE_N   = 9'h1ff;
   localparam logic [8:0] HIGH_TIER_RST = 9'h000;
   localparam logic [3:0] SLOT_BRIDGE  = 4'h9;
   localparam logic [3:0] SLOT_LOW     = 4'ha;
   localparam logic [3:0] OWNER_NONE   = 4'hf;

   typedef enum logic {BUS_PRIMARY, BUS_SECONDARY} bus_type;

   // One transaction request: bus, command and configuration type.
   typedef struct packed {
      bus_type    bus;
      logic [3:0] cmd;
      logic       type1;
   } txn_type;

   localparam int TXN_W = $bits(txn_type);

   typedef enum {ISSUE_IDLE, ISSUE_WAIT_BUS, ISSUE_OFFER} issue_state_type;

   // Commands the bridge may start as master.
   function automatic logic master_ok(txn_type t);
      unique case (t.cmd)
         CMD_SPECIAL, CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR,
         CMD_MEM_RDM, CMD_MEM_WRM, CMD_MEM_RDL, CMD_MEM_WRL:
            return 1'b1;
         CMD_CFG_RD: return t.bus == BUS_SECONDARY;
         CMD_CFG_WR: return t.bus == BUS_SECONDARY || t.type1;
         default:    return 1'b0;
      endcase
   endfunction

   // Commands the bridge may claim as target.
   function automatic logic target_ok(txn_type t);
      unique case (t.cmd)
         CMD_IO_RD, CMD_IO_WR, CMD_MEM_RD, CMD_MEM_WR,
         CMD_MEM_RDM, CMD_MEM_WRM, CMD_MEM_RDL, CMD_MEM_WRL:
            return 1'b1;
         CMD_CFG_RD: return t.bus == BUS_PRIMARY;
         CMD_CFG_WR: return t.bus == BUS_PRIMARY || t.type1;
         default:    return 1'b0;
      endcase
   endfunction

   // Rotating pick: nearest set bit after last among n slots.
   function automatic logic [4:0] rr_pick(logic [10:0] req,
                                          logic [3:0] last, int n);
      int         j;
      logic [4:0] r;
      r = 5'h00;
      for (int i = n; i >= 1; i--) begin
         j = (int'(last) + i) % n;
         if (req[j]) begin
            r = {1'b1, 4'(j)};
         end
      end
      return r;
   endfunction

endpackage

// File: txn_fifo.sv
// Small FIFO with registered read data and valid/ready on both sides.
`timescale 1ns/10ps
module txn_fifo #(
   parameter int WIDTH = 6,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   input  wire logic [WIDTH-1:0] wr_data_in,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in,
   output logic [WIDTH-1:0]      rd_data_out
);
   localparam int AW = $clog2(DEPTH);

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
         $error("txn_fifo: DEPTH must be a power of two >= 2");
      end
   end

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          ready;
      logic          ov;
      logic [WIDTH-1:0] od;
   } fifo_state_type;

   fifo_state_type   s_reg;
   fifo_state_type   s_next;
   logic [WIDTH-1:0] mem [DEPTH];
   logic             push;
   logic             pop;

   // Full counts only the array; the output register is one extra slot.
   assign wr_ready_out = s_reg.ready;
   assign rd_valid_out = s_reg.ov;
   assign rd_data_out  = s_reg.od;
   assign push         = wr_valid_in && wr_ready_out;
   assign pop          = (s_reg.cnt != '0) && (!s_reg.ov || rd_ready_in);

   // Pointer and output register update.
   always_comb begin
      s_next = s_reg;
      if (push) begin
         s_next.wp = s_reg.wp + 1'b1;
      end
      if (pop) begin
         s_next.rp = s_reg.rp + 1'b1;
         s_next.od = mem[s_reg.rp];
         s_next.ov = 1'b1;
      end else if (rd_ready_in) begin
         s_next.ov = 1'b0;
      end
      s_next.cnt = s_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
      // Ready is kept in a flop so the write side sees no logic path.
      s_next.ready = s_next.cnt != (AW + 1)'(DEPTH);
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_reg       <= '0;
         s_reg.ready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Storage array carries no reset so it maps onto plain memory.
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[s_reg.wp] <= wr_data_in;
      end
   end
endmodule

// File: pci_bridge_command_filter.sv
// Command filter, target claim timing and secondary arbiter of the bridge.
`timescale 1ns/10ps
module pci_bridge_command_filter
   import bridge_pkg::*;
#(
   parameter logic [8:0] HIGH_TIER = HIGH_TIER_RST
) (
   input  wire logic                clk_in,
   input  wire logic                resetn_in,
   input  wire logic                p_addr_valid_in,
   input  wire logic [3:0]          p_cmd_in,
   input  wire logic                p_type1_in,
   output logic                     p_devsel_out,
   output logic                     p_hdr_sel_out,
   input  wire logic                s_addr_tgl_in,
   input  wire logic [3:0]          s_cmd_in,
   input  wire logic                s_type1_in,
   output logic                     s_devsel_out,
   input  wire logic                mreq_valid_in,
   output logic                     mreq_ready_out,
   input  wire bridge_pkg::txn_type mreq_txn_in,
   output logic                     issue_valid_out,
   input  wire logic                issue_ready_in,
   output bridge_pkg::txn_type      issue_txn_out,
   output logic                     reject_out,
   input  wire logic [8:0]          req_n_in,
   output logic [8:0]               gnt_n_out,
   input  wire logic                ext_arb_in,
   output logic                     ext_req_n_out,
   input  wire logic                ext_gnt_n_in
);

   initial begin
      if (CLK_MHZ > MAX_BUS_MHZ) begin
         $error("clock rate above the supported bus rate");
      end
   end

   typedef struct packed {
      logic [5:0]      s_meta;
      logic [5:0]      s_sync;
      logic            s_tgl_seen;
      logic [1:0]      pin_meta;
      logic [1:0]      pin_sync;
      logic [8:0]      req_meta;
      logic [8:0]      req_sync;
      logic            p_claim_d1;
      logic            p_hdr_d1;
      logic            p_devsel;
      logic            p_hdr_sel;
      logic            s_claim_d1;
      logic            s_devsel;
      issue_state_type issue_state;
      txn_type         hold;
      logic            issue_valid;
      logic            reject;
      logic [3:0]      owner;
      logic [3:0]      hi_last;
      logic [3:0]      lo_last;
      logic [8:0]      gnt_n;
      logic            ext_req_n;
   } state_type;

   state_type   st_reg;
   state_type   st_next;
   logic [1:0]  rst_chain;
   logic        rst_n;
   logic        fifo_valid;
   logic        fifo_ready;
   txn_type     fifo_txn;
   txn_type     p_txn;
   txn_type     s_txn;
   logic        s_evt;
   logic        ext_mode;
   logic        ext_gnt;
   logic        bus_granted;
   logic        bridge_req;

   // Reset release through two flops; only the second one is used.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_chain <= 2'h0;
      end else begin
         rst_chain <= {rst_chain[0], 1'b1};
      end
   end
   assign rst_n = rst_chain[1];

   // Outbound master requests queue here; the drain stalls while the issue sequencer is busy.
   txn_fifo #(
      .WIDTH (TXN_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n),
      .wr_valid_in  (mreq_valid_in),
      .wr_ready_out (mreq_ready_out),
      .wr_data_in   (mreq_txn_in),
      .rd_valid_out (fifo_valid),
      .rd_ready_in  (fifo_ready),
      .rd_data_out  (fifo_txn)
   );

   // Decoded views of the primary inputs and the synchronised secondary-side and arbiter pins.
   assign p_txn       = '{bus: BUS_PRIMARY, cmd: p_cmd_in, type1: p_type1_in};
   assign s_txn       = '{bus: BUS_SECONDARY, cmd: st_reg.s_sync[4:1],
                          type1: st_reg.s_sync[0]};
   assign s_evt       = st_reg.s_sync[5] != st_reg.s_tgl_seen;
   assign ext_mode    = st_reg.pin_sync[1];
   assign ext_gnt     = !st_reg.pin_sync[0];
   assign fifo_ready  = st_reg.issue_state == ISSUE_IDLE;
   assign bridge_req  = st_reg.issue_state != ISSUE_IDLE
                        && st_reg.hold.bus == BUS_SECONDARY;
   assign bus_granted = ext_mode ? ext_gnt : st_reg.owner == SLOT_BRIDGE;

   // Whole next-state of the block.
   always_comb begin
      logic [10:0] hi_req;
      logic [10:0] lo_req;
      logic [8:0]  req;
      logic [4:0]  pick;
      logic        owner_busy;
      hi_req     = 11'h000;
      lo_req     = 11'h000;
      pick       = 5'h00;
      owner_busy = 1'b0;
      st_next = st_reg;
      req     = ~st_reg.req_sync;
      // Secondary pins cross through two flops before use.
      st_next.s_meta   = {s_addr_tgl_in, s_cmd_in, s_type1_in};
      st_next.s_sync   = st_reg.s_meta;
      st_next.s_tgl_seen = st_reg.s_sync[5];
      st_next.pin_meta = {ext_arb_in, ext_gnt_n_in};
      st_next.pin_sync = st_reg.pin_meta;
      st_next.req_meta = req_n_in;
      st_next.req_sync = st_reg.req_meta;

      // Claim decision, then device select two cycles on.
      st_next.p_claim_d1 = p_addr_valid_in && target_ok(p_txn);
      st_next.p_hdr_d1   = p_addr_valid_in && !p_type1_in
                           && (p_cmd_in == CMD_CFG_RD
                               || p_cmd_in == CMD_CFG_WR);
      st_next.p_devsel   = st_reg.p_claim_d1;
      st_next.p_hdr_sel  = st_reg.p_hdr_d1;
      // Secondary never reaches the header, only forwarding claims.
      st_next.s_claim_d1 = s_evt && target_ok(s_txn);
      st_next.s_devsel   = st_reg.s_claim_d1;

      // Master issue sequencer.
      st_next.reject = 1'b0;
      unique case (st_reg.issue_state)
         ISSUE_IDLE: begin
            if (fifo_valid) begin
               st_next.hold = fifo_txn;
               if (!master_ok(fifo_txn)) begin
                  st_next.reject = 1'b1;
               end else if (fifo_txn.bus == BUS_PRIMARY) begin
                  st_next.issue_state = ISSUE_OFFER;
               end else begin
                  st_next.issue_state = ISSUE_WAIT_BUS;
               end
            end
         end
         ISSUE_WAIT_BUS: begin
            if (bus_granted) begin
               st_next.issue_state = ISSUE_OFFER;
            end
         end
         ISSUE_OFFER: begin
            if (issue_ready_in) begin
               st_next.issue_state = ISSUE_IDLE;
            end
         end
      endcase
      st_next.issue_valid = st_next.issue_state == ISSUE_OFFER;

      // Two-tier arbiter: the low tier is a single slot of the high one.
      lo_req = {2'b00, req & ~HIGH_TIER};
      hi_req = {|lo_req, bridge_req, req & HIGH_TIER};
      owner_busy = (st_reg.owner == SLOT_BRIDGE) ? bridge_req
                   : (st_reg.owner < SLOT_BRIDGE) ? req[st_reg.owner]
                   : 1'b0;
      if (ext_mode) begin
         st_next.owner = OWNER_NONE;
      end else if (!owner_busy) begin
         st_next.owner = OWNER_NONE;
         pick = rr_pick(hi_req, st_reg.hi_last, NUM_MASTERS + 2);
         if (pick[4]) begin
            st_next.hi_last = pick[3:0];
            st_next.owner   = pick[3:0];
            if (pick[3:0] == SLOT_LOW) begin
               pick = rr_pick(lo_req, st_reg.lo_last, NUM_MASTERS);
               st_next.lo_last = pick[3:0];
               st_next.owner   = pick[3:0];
            end
         end
      end
      for (int i = 0; i < NUM_MASTERS; i++) begin
         st_next.gnt_n[i] = !(st_next.owner == 4'(i));
      end
      st_next.ext_req_n = !(ext_mode && bridge_req);
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         st_reg             <= '0;
         st_reg.owner       <= OWNER_NONE;
         st_reg.gnt_n       <= GNT_IDLE_N;
         st_reg.ext_req_n   <= 1'b1;
         st_reg.req_meta    <= GNT_IDLE_N;
         st_reg.req_sync    <= GNT_IDLE_N;
         st_reg.pin_meta    <= 2'h1;
         st_reg.pin_sync    <= 2'h1;
         st_reg.issue_state <= ISSUE_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // All outputs but mreq_ready_out come straight from the state register.
   assign p_devsel_out    = st_reg.p_devsel;
   assign p_hdr_sel_out   = st_reg.p_hdr_sel;
   assign s_devsel_out    = st_reg.s_devsel;
   assign issue_valid_out = st_reg.issue_valid;
   assign issue_txn_out   = st_reg.hold;
   assign reject_out      = st_reg.reject;
   assign gnt_n_out       = st_reg.gnt_n;
   assign ext_req_n_out   = st_reg.ext_req_n;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n);

   // Rule checks sit next to the logic; they only watch what we drive.
   a_intack_no_issue: assert property (
      issue_valid_out |-> issue_txn_out.cmd != CMD_INTACK)
      else $error("interrupt acknowledge issued");
   a_intack_no_claim: assert property (
      p_addr_valid_in && p_cmd_in == CMD_INTACK |-> ##2 !p_devsel_out)
      else $error("interrupt acknowledge claimed");
   a_special_no_claim: assert property (
      s_evt && s_txn.cmd == CMD_SPECIAL |-> ##2 !s_devsel_out)
      else $error("special cycle claimed on secondary");
   a_mem_claim_time: assert property (
      !$past(p_addr_valid_in) && p_addr_valid_in && p_cmd_in == CMD_MEM_RD
      |-> ##1 !p_devsel_out ##1 p_devsel_out)
      else $error("memory read not claimed two cycles on");
   a_cfgrd_issue_bus: assert property (
      issue_valid_out && issue_txn_out.cmd == CMD_CFG_RD
      |-> issue_txn_out.bus == BUS_SECONDARY)
      else $error("config read issued on primary");
   a_cfgwr_pri_type1: assert property (
      issue_valid_out && issue_txn_out.cmd == CMD_CFG_WR
      && issue_txn_out.bus == BUS_PRIMARY |-> issue_txn_out.type1)
      else $error("type 0 config write issued on primary");
   a_reserved_drop: assert property (
      fifo_valid && fifo_ready
      && fifo_txn.cmd inside {4'h4, 4'h5, 4'h8, 4'h9}
      |=> reject_out && !issue_valid_out)
      else $error("reserved command not rejected");
   a_hdr_primary: assert property (
      p_hdr_sel_out |-> p_devsel_out && $past(p_addr_valid_in, 2))
      else $error("header select without primary access");
   a_grant_onehot: assert property (
      $onehot0(~gnt_n_out))
      else $error("more than one grant");
   a_ext_no_grant: assert property (
      ext_mode |=> gnt_n_out == GNT_IDLE_N)
      else $error("grant driven in external mode");
   a_sec_claim_lat: assert property (
      s_evt && s_txn.cmd == CMD_MEM_WR |-> ##2 s_devsel_out)
      else $error("secondary claim latency wrong");
   a_cfgrd_no_sec: assert property (
      s_evt && s_txn.cmd == CMD_CFG_RD |-> ##2 !s_devsel_out)
      else $error("config read claimed on secondary");
   a_type0_no_sec: assert property (
      s_evt && s_txn.cmd == CMD_CFG_WR && !s_txn.type1
      |-> ##2 !s_devsel_out)
      else $error("type 0 config write claimed on secondary");
   a_ext_req_idle: assert property (
      !ext_mode |=> ext_req_n_out)
      else $error("external request raised in internal mode");
   a_bridge_tier: assert property (
      !ext_mode && st_reg.owner == OWNER_NONE && bridge_req
      && st_reg.hi_last != SLOT_BRIDGE
      && (~st_reg.req_sync & HIGH_TIER) == 9'h000
      |=> st_reg.owner == SLOT_BRIDGE)
      else $error("bridge lost the bus to the low tier");

   // Main scenarios that the bench is expected to reach.
   c_pri_claim: cover property (p_addr_valid_in ##2 p_devsel_out);
   c_reject: cover property (reject_out);
   c_sec_issue: cover property (bridge_req ##[1:20] issue_valid_out);
   c_grant_low: cover property (!ext_mode && gnt_n_out != GNT_IDLE_N);
   c_fifo_full: cover property (!mreq_ready_out);
endmodule

// File: far_side.sv
// Far-side model: issue stream consumer and external secondary arbiter.
`timescale 1ns/10ps
module far_side
   import bridge_pkg::*;
(
   input  wire logic    clk_in,
   input  wire logic    stall_in,
   input  wire logic    issue_valid_in,
   output logic         issue_ready_out,
   input  wire txn_type issue_txn_in,
   output logic         took_out,
   output txn_type      took_txn_out,
   input  wire logic    ext_req_n_in,
   output logic         ext_gnt_n_out
);
   logic [1:0] wait_cnt;

   initial begin
      issue_ready_out = 1'b0;
      took_out = 1'b0;
      took_txn_out = '0;
      ext_gnt_n_out = 1'b1;
      wait_cnt = 2'h0;
   end

   // A stall withholds ready, so the bridge must hold its offer.
   always @(posedge clk_in) begin
      took_out <= issue_valid_in && issue_ready_out;
      took_txn_out <= issue_txn_in;
      issue_ready_out <= #1 !stall_in;
   end

   // Grant comes three cycles after a request and drops with it.
   always @(posedge clk_in) begin
      if (ext_req_n_in) begin
         wait_cnt <= 2'h0;
         ext_gnt_n_out <= #1 1'b1;
      end else if (wait_cnt == 2'h2) begin
         ext_gnt_n_out <= #1 1'b0;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule

// File: testbench.sv
// Self-checking bench for the bridge command filter and arbiter.
`timescale 1ns/10ps
module testbench;
   import bridge_pkg::*;
   logic       clk_in = 0, resetn_in = 0, p_addr_valid_in = 0;
   logic [3:0] p_cmd_in = 0, s_cmd_in = 0;
   logic       p_type1_in = 0, s_type1_in = 0, s_addr_tgl_in = 0;
   logic       p_devsel_out, p_hdr_sel_out, s_devsel_out;
   logic       mreq_valid_in = 0, mreq_ready_out, issue_valid_out;
   logic       issue_ready_in, reject_out, ext_arb_in = 0;
   logic       ext_req_n_out, ext_gnt_n_in, stall = 0, took;
   txn_type    mreq_txn_in = '0, issue_txn_out, took_txn;
   logic [8:0] req_n_in = 9'h1ff, gnt_n_out;
   int         error_cnt = 0, n_compared = 0;

   pci_bridge_command_filter dut (
      .clk_in          (clk_in),
      .resetn_in       (resetn_in),
      .p_addr_valid_in (p_addr_valid_in),
      .p_cmd_in        (p_cmd_in),
      .p_type1_in      (p_type1_in),
      .p_devsel_out    (p_devsel_out),
      .p_hdr_sel_out   (p_hdr_sel_out),
      .s_addr_tgl_in   (s_addr_tgl_in),
      .s_cmd_in        (s_cmd_in),
      .s_type1_in      (s_type1_in),
      .s_devsel_out    (s_devsel_out),
      .mreq_valid_in   (mreq_valid_in),
      .mreq_ready_out  (mreq_ready_out),
      .mreq_txn_in     (mreq_txn_in),
      .issue_valid_out (issue_valid_out),
      .issue_ready_in  (issue_ready_in),
      .issue_txn_out   (issue_txn_out),
      .reject_out      (reject_out),
      .req_n_in        (req_n_in),
      .gnt_n_out       (gnt_n_out),
      .ext_arb_in      (ext_arb_in),
      .ext_req_n_out   (ext_req_n_out),
      .ext_gnt_n_in    (ext_gnt_n_in)
   );
   far_side partner (.clk_in(clk_in), .stall_in(stall),
      .issue_valid_in(issue_valid_out), .issue_ready_out(issue_ready_in),
      .issue_txn_in(issue_txn_out), .took_out(took),
      .took_txn_out(took_txn), .ext_req_n_in(ext_req_n_out),
      .ext_gnt_n_out(ext_gnt_n_in));

   // Free-running 50 MHz clock.
   always #10 clk_in = ~clk_in;

   task automatic tick(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic check(input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         error_cnt++;
      end
   endtask

   task automatic end_sim();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   function automatic logic io_mem(logic [3:0] c);
      return c inside {4'h2, 4'h3, 4'h6, 4'h7, [4'hc:4'hf]};
   endfunction

   // Every code and type on the primary side; claim must land at cycle 2.
   task automatic prim_claim();
      int pos;
      logic hdr;
      for (int c = 0; c < 32; c++) begin
         {p_cmd_in, p_type1_in} = 5'(c);
         p_addr_valid_in = 1'b1;
         tick(1);
         p_addr_valid_in = 1'b0;
         pos = 0;
         hdr = 1'b0;
         for (int k = 1; k < 6; k++) begin
            if (p_devsel_out === 1'b1 && pos == 0) begin
               pos = k;
               hdr = p_hdr_sel_out;
            end
            tick(1);
         end
         check(16'(pos), (io_mem(p_cmd_in) || p_cmd_in inside {4'ha, 4'hb})
               ? 16'h2 : 16'h0);
         check(16'(hdr), 16'(!p_type1_in && p_cmd_in inside {4'ha, 4'hb}));
      end
   endtask

   // Every code and type on the secondary side; one pulse if claimable.
   task automatic sec_claim();
      int cnt;
      for (int c = 0; c < 32; c++) begin
         {s_cmd_in, s_type1_in} = 5'(c);
         tick(3);
         s_addr_tgl_in = ~s_addr_tgl_in;
         cnt = 0;
         for (int k = 0; k < 10; k++) begin
            tick(1);
            cnt += int'(s_devsel_out === 1'b1);
         end
         check(16'(cnt), 16'(io_mem(s_cmd_in) ||
               (s_cmd_in == 4'hb && s_type1_in)));
      end
   endtask

   // Offer one master request, held until the FIFO takes it.
   task automatic push(txn_type t);
      mreq_txn_in = t;
      mreq_valid_in = 1'b1;
      for (int k = 0; k < 40 && mreq_ready_out !== 1'b1; k++) tick(1);
      check(16'(mreq_ready_out), 16'h1);
      tick(1);
      mreq_valid_in = 1'b0;
   endtask

   // Returns 1 when the partner took the command, 2 on a reject.
   task automatic outcome(output int res, output txn_type got);
      res = 0;
      for (int k = 0; k < 60 && res == 0; k++) begin
         if (took === 1'b1) res = 1;
         if (reject_out === 1'b1) res = 2;
         got = took_txn;
         tick(1);
      end
   endtask

   task automatic issue_all();
      txn_type t, got;
      int res;
      logic ok;
      for (int i = 0; i < 64; i++) begin
         t = txn_type'(6'(i));
         ok = io_mem(t.cmd) || t.cmd == 4'h1 ||
              (t.cmd == 4'ha && t.bus == BUS_SECONDARY) ||
              (t.cmd == 4'hb && (t.bus == BUS_SECONDARY || t.type1));
         push(t);
         outcome(res, got);
         check(16'(res), ok ? 16'h1 : 16'h2);
         if (ok) check(16'(got), 16'(t));
      end
   endtask

   // Fill the FIFO under a stall until it refuses, then drain in order.
   task automatic fifo_fill();
      int n, m;
      logic rdy;
      stall = 1'b1;
      tick(4);
      n = 0;
      mreq_valid_in = 1'b1;
      for (int k = 0; k < 24; k++) begin
         mreq_txn_in = '{BUS_PRIMARY, 4'hc + 4'(n % 4), 1'b0};
         rdy = mreq_ready_out;
         tick(1);
         n += int'(rdy === 1'b1);
      end
      mreq_valid_in = 1'b0;
      check(16'(n >= FIFO_DEPTH && n <= FIFO_DEPTH + 2), 16'h1);
      check(16'(mreq_ready_out), 16'h0);
      stall = 1'b0;
      m = 0;
      for (int k = 0; k < 200; k++) begin
         if (took === 1'b1) begin
            check(16'(took_txn.cmd), 16'(4'hc + 4'(m % 4)));
            m++;
         end
         tick(1);
      end
      check(16'(m), 16'(n));
   endtask

   task automatic wait_gnt(logic [8:0] exp);
      for (int k = 0; k < 12 && gnt_n_out !== exp; k++) tick(1);
   endtask

   // Each of the nine pairs alone, then two low-tier masters rotating.
   task automatic arb_test();
      int first;
      logic [8:0] one_n;
      for (int i = 0; i < NUM_MASTERS; i++) begin
         one_n = ~(9'h1 << i);
         req_n_in = one_n;
         wait_gnt(one_n);
         check(16'(gnt_n_out), 16'(one_n));
         req_n_in = 9'h1ff;
         wait_gnt(9'h1ff);
         check(16'(gnt_n_out), 16'h1ff);
      end
      req_n_in = 9'h1d7;
      for (int k = 0; k < 12 && gnt_n_out === 9'h1ff; k++) tick(1);
      first = (gnt_n_out === 9'h1f7) ? 3 : 5;
      req_n_in[first] = 1'b1;
      one_n = ~(9'h1 << (8 - first));
      wait_gnt(one_n);
      check(16'(gnt_n_out), 16'(one_n));
      req_n_in = 9'h1ff;
      tick(8);
   endtask

   // External arbiter mode: no internal grants, bridge still issues.
   task automatic ext_test();
      txn_type got;
      int res;
      ext_arb_in = 1'b1;
      tick(4);
      req_n_in = 9'h0fe;
      tick(8);
      check(16'(gnt_n_out), 16'h1ff);
      push('{BUS_SECONDARY, 4'h6, 1'b0});
      outcome(res, got);
      check(16'(res), 16'h1);
      check(16'(ext_req_n_out), 16'h1);
      req_n_in = 9'h1ff;
      ext_arb_in = 1'b0;
      tick(8);
   endtask

   // Hang guard well above the expected run time.
   initial begin
      #1_500_000;
      error_cnt++;
      end_sim();
   end

   initial begin
      repeat (6) @(posedge clk_in);
      #1;
      resetn_in = 1'b1;
      tick(4);
      check(16'(gnt_n_out), 16'h1ff);
      prim_claim();
      sec_claim();
      issue_all();
      fifo_fill();
      arb_test();
      ext_test();
      end_sim();
   end
endmodule
